/* src/cfgld_top.sv */
// serial configuration frame loader with start-up sequencer and wishbone registers
// How it works
// - start-up needs length count match and end frame
// - three start-up events in any programmed order
// - user clock modes time start-up on user clock
// - synced modes count from seen completion pin
// - completion pin open drain, pull-up on default
// - default synced, pin released on first edge
// - in synced modes a low completion line withholds other two events
// - gsr and io delay zero to four edges, done delay zero to seven
// - both events immediate by default
// - program request low clears and reloads device
// - previous load option can skip memory clear
// - previous load options disable gsr, tristate, clear
// - autoincrement or explicit frame addressing
// - header: ones, preamble, 24-bit length
// - identification frame follows header, part checked
// - every frame checksum always verified
// - addressing mode taken from identification frame
// - data frame 01 start, ones stop to byte
// - explicit data stored at each following address
// - postamble: all-ones address, all-ones checksum
// - mode field 00 auto, 01 explicit
// - address frame 00 header, 14-bit address
// - checksum is xor of frame bytes
// - errors park device with init held low
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`include "cfgld_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module cfgld_top #(
	parameter int DATA_BITS = 202,
	parameter logic [19:0] PART_ID = `CFGLD_PART_ID_DEF // arbitrary value
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// configuration link
	input wire logic config_bit_clock_i,
	input wire logic cfg_data_i,
	input wire logic program_request_n_i,
	input wire logic user_startup_clock_i,
	input wire logic [1:0] mode_sel_i,
	// completion pin, open drain
	input wire logic done_i,
	output logic done_o,
	output logic done_oe_o,
	output logic done_pullup_en_o,
	// status and global controls
	output logic init_n_o,
	output logic gsr_hold_o,
	output logic io_active_o,
	// configuration memory write port
	output logic cfg_mem_clear_o,
	output logic cfg_mem_we_o,
	output logic [13:0] cfg_mem_addr_o,
	output logic [DATA_BITS-1:0] cfg_mem_data_o
);
	// frame length rounded up to a byte boundary (start pair plus data)
	localparam int DLEN = ((DATA_BITS + 2 + 7) / 8) * 8;
	localparam logic [9:0] DATA_LAST = 10'(DLEN - 1);
	localparam logic [9:0] DATA_END = 10'(DATA_BITS + 2);

	// ==========================================================
	// input synchronisers
	logic [5:0] sync1_r; // first stage, read only by second
	logic [5:0] sync2_r;
	logic config_bit_clock_d_r; // previous config clock level
	logic user_startup_clock_d_r; // previous user clock level
	always_ff @(posedge clk_i) begin
		sync1_r <= {mode_sel_i, done_i, program_request_n_i, user_startup_clock_i,
			config_bit_clock_i};
		sync2_r <= sync1_r;
		config_bit_clock_d_r <= sync2_r[0];
		user_startup_clock_d_r <= sync2_r[1];
	end
	wire config_bit_clock_rise = sync2_r[0] & ~config_bit_clock_d_r;
	wire user_startup_clock_rise = sync2_r[1] & ~user_startup_clock_d_r;
	wire prog_n_s = sync2_r[2];
	wire done_s = sync2_r[3];
	wire [1:0] mode_s = sync2_r[5:4];
	// data travels the same two stages as its clock, so it lines up with the edge
	logic data_s1_r;
	logic data_s2_r;
	always_ff @(posedge clk_i) begin
		data_s1_r <= cfg_data_i;
		data_s2_r <= data_s1_r;
	end
	wire bit_d = data_s2_r;

	// ==========================================================
	// registers and shared state
	cfgld_pkg::cfgld_top_st_t top_st_r, top_st_nxt;
	cfgld_pkg::cfgld_parse_st_t pst_r;
	cfgld_pkg::cfgld_ctrl_t ctrl_r; // software start-up control
	cfgld_pkg::cfgld_ev_t ev_r; // start-up events reached
	cfgld_pkg::cfgld_opt_t opt_r; // options from the last good load
	cfgld_pkg::cfgld_opt_t opt_nxt_r; // options of the load in progress
	logic [1:0] mode_smp_r; // mode pins sampled after init
	logic [1:0] init_cnt_r;
	logic [23:0] len_r; // loaded length count
	logic len_ok_r;
	logic [23:0] cnt_r; // config clocks seen
	logic len_hit_r;
	logic eoc_r; // end frame written
	logic [2:0] err_r; // {checksum, alignment, id}
	wire bit_v = config_bit_clock_rise & (top_st_r == cfgld_pkg::S_CFG);

	// ==========================================================
	// top level sequencing
	always_comb begin
		top_st_nxt = top_st_r;
		case (top_st_r)
			cfgld_pkg::S_CLR: begin
				// stay cleared while the request pin is held low
				if (prog_n_s) begin
					top_st_nxt = cfgld_pkg::S_INIT;
				end
			end
			cfgld_pkg::S_INIT: begin
				if (init_cnt_r == `CFGLD_INIT_CYC) begin
					top_st_nxt = cfgld_pkg::S_CFG;
				end
			end
			cfgld_pkg::S_CFG: begin
				if (pst_r == cfgld_pkg::P_ERR) begin
					top_st_nxt = cfgld_pkg::S_ERR;
				end else if (eoc_r && len_hit_r) begin
					top_st_nxt = cfgld_pkg::S_START;
				end
			end
			cfgld_pkg::S_START: begin
				if (ev_r == 3'h7) begin
					top_st_nxt = cfgld_pkg::S_RUN;
				end
			end
			cfgld_pkg::S_RUN: top_st_nxt = cfgld_pkg::S_RUN;
			cfgld_pkg::S_ERR: top_st_nxt = cfgld_pkg::S_ERR;
			default: top_st_nxt = cfgld_pkg::S_CLR;
		endcase
		// a low request aborts or reconfigures from any phase
		if (!prog_n_s) begin
			top_st_nxt = cfgld_pkg::S_CLR;
		end
	end

	// phase register, init counter and mode sampling
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			top_st_r <= cfgld_pkg::S_CLR;
			init_cnt_r <= 2'h0;
			mode_smp_r <= 2'h0;
		end else begin
			top_st_r <= top_st_nxt;
			init_cnt_r <= (top_st_r == cfgld_pkg::S_INIT) ? init_cnt_r + 2'h1 : 2'h0;
			if (top_st_r == cfgld_pkg::S_INIT && top_st_nxt == cfgld_pkg::S_CFG) begin
				mode_smp_r <= mode_s;
			end
		end
	end

	// init low while clearing or parked on an error; memory clear unless skipped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_n_o <= 1'b0;
			cfg_mem_clear_o <= 1'b0;
		end else begin
			init_n_o <= top_st_nxt != cfgld_pkg::S_CLR && top_st_nxt != cfgld_pkg::S_ERR;
			cfg_mem_clear_o <= top_st_nxt == cfgld_pkg::S_CLR && !opt_r.no_clear;
		end
	end

	// ==========================================================
	// length counter
	always_ff @(posedge clk_i) begin
		if (rst_i || top_st_r == cfgld_pkg::S_CLR) begin
			cnt_r <= 24'h000000;
			len_hit_r <= 1'b0;
		end else begin
			if (bit_v) begin
				cnt_r <= cnt_r + 24'h000001;
			end
			if (len_ok_r && cnt_r == len_r) begin
				len_hit_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// bit stream parser
	logic [4:0] win_r; // preamble hunt window
	logic [9:0] fbit_r; // bit index within a field or frame
	logic [3:0] stop_cnt_r;
	logic [31:0] w_sr_r; // recent frame bits
	logic [7:0] byte_r;
	logic [7:0] xor_r; // running checksum
	logic [7:0] cs_sr_r;
	logic [2:0] cb_r;
	logic id_done_r;
	logic is_data_r;
	logic expl_r; // explicit addressing for this load
	logic [13:0] fa_r; // frame address just received
	logic [13:0] addr_r; // next implied address
	logic [DATA_BITS-1:0] data_sr_r;
	wire [15:0] w16 = {w_sr_r[14:0], bit_d};
	wire [7:0] cs_in = {cs_sr_r[6:0], bit_d};
	wire is_post = id_done_r && !is_data_r && fa_r == `CFGLD_POST_ADDR;
	wire csum_bad = is_post ? cs_in != `CFGLD_POST_CSUM : cs_in != xor_r;
	wire fend = !id_done_r ? fbit_r == `CFGLD_ID_LAST :
		is_data_r ? fbit_r == DATA_LAST : fbit_r == `CFGLD_ADDR_LAST;
	wire in_data = is_data_r && fbit_r >= `CFGLD_DATA_FIRST && fbit_r < DATA_END;

	always_ff @(posedge clk_i) begin
		if (rst_i || top_st_r == cfgld_pkg::S_CLR) begin
			pst_r <= cfgld_pkg::P_HUNT;
			win_r <= 5'h00;
			fbit_r <= 10'h000;
			stop_cnt_r <= 4'h0;
			w_sr_r <= 32'h00000000;
			byte_r <= 8'h00;
			xor_r <= 8'h00;
			cs_sr_r <= 8'h00;
			cb_r <= 3'h0;
			id_done_r <= 1'b0;
			is_data_r <= 1'b0;
			expl_r <= 1'b0;
			fa_r <= 14'h0000;
			addr_r <= 14'h0000;
			len_r <= 24'h000000;
			len_ok_r <= 1'b0;
			eoc_r <= 1'b0;
			err_r <= 3'h0;
			opt_nxt_r <= 3'h0;
			cfg_mem_we_o <= 1'b0;
		end else begin
			cfg_mem_we_o <= 1'b0;
			if (bit_v) begin
				case (pst_r)
					cfgld_pkg::P_HUNT: begin
						// a one followed by the preamble opens the header
						win_r <= {win_r[3:0], bit_d};
						if ({win_r[3:0], bit_d} == `CFGLD_PRE_WIN) begin
							pst_r <= cfgld_pkg::P_LEN;
							fbit_r <= 10'h000;
						end
					end
					cfgld_pkg::P_LEN: begin
						len_r <= {len_r[22:0], bit_d};
						fbit_r <= fbit_r + 10'h001;
						if (fbit_r == `CFGLD_LEN_LAST) begin
							len_ok_r <= 1'b1;
							pst_r <= cfgld_pkg::P_STOP;
							stop_cnt_r <= 4'h0;
						end
					end
					cfgld_pkg::P_STOP: begin
						if (bit_d) begin
							if (stop_cnt_r != `CFGLD_STOP_BITS) begin
								stop_cnt_r <= stop_cnt_r + 4'h1;
							end
						end else if (stop_cnt_r == `CFGLD_STOP_BITS) begin
							// the zero is bit 0 of the next frame
							pst_r <= cfgld_pkg::P_FRM;
							fbit_r <= 10'h001;
							w_sr_r <= 32'h00000000;
							byte_r <= 8'h00;
							xor_r <= 8'h00;
						end else begin
							pst_r <= cfgld_pkg::P_ERR;
							err_r[1] <= 1'b1;
						end
					end
					cfgld_pkg::P_FRM: begin
						w_sr_r <= {w_sr_r[30:0], bit_d};
						byte_r <= {byte_r[6:0], bit_d};
						fbit_r <= fbit_r + 10'h001;
						if (fbit_r[2:0] == `CFGLD_BYTE_LAST) begin
							xor_r <= xor_r ^ {byte_r[6:0], bit_d};
						end
						if (fbit_r == 10'h001) begin
							is_data_r <= bit_d;
						end
						if (in_data) begin
							data_sr_r <= {data_sr_r[DATA_BITS-2:0], bit_d};
						end
						if (!id_done_r) begin
							// identification frame fields
							if (fbit_r == `CFGLD_ID_HDR_LAST && w16 != `CFGLD_ID_HDR) begin
								pst_r <= cfgld_pkg::P_ERR;
								err_r[0] <= 1'b1;
							end
							if (fbit_r == `CFGLD_ID_MODE_LAST) begin
								expl_r <= w16[1:0] == `CFGLD_MODE_EXPL;
								if (w16[1:0] != `CFGLD_MODE_AUTO && w16[1:0] != `CFGLD_MODE_EXPL) begin
									pst_r <= cfgld_pkg::P_ERR;
									err_r[0] <= 1'b1;
								end
							end
							if (fbit_r == `CFGLD_ID_OPT_LAST) begin
								opt_nxt_r <= w16[2:0];
							end
						end
						if (fend) begin
							fa_r <= w16[13:0];
							cb_r <= 3'h0;
							pst_r <= cfgld_pkg::P_CSUM;
							if (!id_done_r && {w_sr_r[18:0], bit_d} != PART_ID) begin
								pst_r <= cfgld_pkg::P_ERR;
								err_r[0] <= 1'b1;
							end
						end
					end
					cfgld_pkg::P_CSUM: begin
						cs_sr_r <= cs_in;
						cb_r <= cb_r + 3'h1;
						if (cb_r == `CFGLD_BYTE_LAST) begin
							pst_r <= cfgld_pkg::P_STOP;
							stop_cnt_r <= 4'h0;
							if (csum_bad) begin
								pst_r <= cfgld_pkg::P_ERR;
								err_r[2] <= 1'b1;
							end else if (is_post) begin
								pst_r <= cfgld_pkg::P_DONE;
								eoc_r <= 1'b1;
							end else if (!id_done_r) begin
								id_done_r <= 1'b1;
							end else if (is_data_r && !expl_r) begin
								cfg_mem_we_o <= 1'b1;
								cfg_mem_addr_o <= addr_r;
								cfg_mem_data_o <= data_sr_r;
								addr_r <= addr_r + 14'h0001;
							end else if (!is_data_r && expl_r) begin
								cfg_mem_we_o <= 1'b1;
								cfg_mem_addr_o <= fa_r;
								cfg_mem_data_o <= data_sr_r;
							end else if (!is_data_r) begin
								addr_r <= fa_r; // moves the implied address
							end
						end
					end
					cfgld_pkg::P_DONE: pst_r <= cfgld_pkg::P_DONE;
					cfgld_pkg::P_ERR: pst_r <= cfgld_pkg::P_ERR;
					default: pst_r <= cfgld_pkg::P_ERR;
				endcase
			end
		end
	end

	// options of a good load steer the next reconfiguration only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opt_r <= 3'h0;
		end else if (top_st_r == cfgld_pkg::S_CFG && top_st_nxt == cfgld_pkg::S_START) begin
			opt_r <= opt_nxt_r;
		end
	end

	// ==========================================================
	// start-up sequencer
	wire user_clk = ctrl_r.mode[1];
	wire synced = ctrl_r.mode[0];
	wire step_e = user_clk ? user_startup_clock_rise : config_bit_clock_rise;
	wire [2:0] gdly = (ctrl_r.gsr_dly > `CFGLD_DLY_MAX) ? `CFGLD_DLY_MAX : ctrl_r.gsr_dly;
	wire [2:0] idly = (ctrl_r.io_dly > `CFGLD_DLY_MAX) ? `CFGLD_DLY_MAX : ctrl_r.io_dly;
	logic [2:0] st_cnt_r; // edges since start-up began
	logic [2:0] di_cnt_r; // edges since completion seen high
	logic done_seen_r;
	wire gsr_go = synced ? done_seen_r && di_cnt_r >= gdly : st_cnt_r >= gdly;
	wire io_go = synced ? done_seen_r && di_cnt_r >= idly : st_cnt_r >= idly;
	wire in_start = top_st_r == cfgld_pkg::S_START;

	// edge counters and completion observation
	always_ff @(posedge clk_i) begin
		if (rst_i || !in_start) begin
			st_cnt_r <= 3'h0;
			di_cnt_r <= 3'h0;
			done_seen_r <= 1'b0;
		end else begin
			if (step_e && st_cnt_r != `CFGLD_CNT_SAT) begin
				st_cnt_r <= st_cnt_r + 3'h1;
			end
			if (ev_r.done_rel && done_s) begin
				done_seen_r <= 1'b1;
			end
			if (step_e && done_seen_r && di_cnt_r != `CFGLD_CNT_SAT) begin
				di_cnt_r <= di_cnt_r + 3'h1;
			end
		end
	end

	// events are sticky once reached; clearing drops done_rel, keeps gsr_rel and io_act per stored options
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_r <= 3'h0;
		end else if (top_st_r == cfgld_pkg::S_CLR) begin
			ev_r.done_rel <= 1'b0;
			ev_r.gsr_rel <= ev_r.gsr_rel & opt_r.no_gsr;
			ev_r.io_act <= ev_r.io_act & opt_r.no_tri;
		end else if (in_start) begin
			// each event on its own condition, so any order results
			ev_r.done_rel <= ev_r.done_rel | (st_cnt_r >= ctrl_r.done_dly);
			ev_r.gsr_rel <= ev_r.gsr_rel | gsr_go;
			ev_r.io_act <= ev_r.io_act | io_go;
		end
	end

	// open drain: only ever pulls low
	assign done_o = 1'b0;
	assign done_oe_o = ~ev_r.done_rel;
	assign done_pullup_en_o = ctrl_r.pullup_en;
	assign gsr_hold_o = ~ev_r.gsr_rel;
	assign io_active_o = ev_r.io_act;

	// ==========================================================
	// wishbone slave, one wait state on every access
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire sel_ctrl = wb_adr_i == `CFGLD_ADR_CTRL;
	wire [31:0] stat_w = {14'h0000, opt_r, mode_smp_r, len_hit_r, eoc_r, ev_r.io_act,
		ev_r.gsr_rel, done_s, expl_r, err_r, 1'b0, top_st_r};
	wire [31:0] rd_mux = sel_ctrl ? {20'h00000, ctrl_r} :
		(wb_adr_i == `CFGLD_ADR_STAT) ? stat_w :
		(wb_adr_i == `CFGLD_ADR_LEN) ? {8'h00, len_r} :
		(wb_adr_i == `CFGLD_ADR_CNT) ? {8'h00, cnt_r} : 32'h00000000;

	// acknowledge and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_mux : 32'h00000000;
		end
	end

	// control register, byte lanes honoured
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `CFGLD_CTRL_RST;
		end else if (wb_req && wb_we_i && sel_ctrl) begin
			if (wb_sel_i[0]) begin
				ctrl_r[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				ctrl_r[11:8] <= wb_dat_i[11:8];
			end
		end
	end

	// ==========================================================
	// checks
	sequence s_su_entry;
		top_st_r == cfgld_pkg::S_START && st_cnt_r == 3'h0 && step_e;
	endsequence
	a_start_cond: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(top_st_r == cfgld_pkg::S_START) |-> $past(eoc_r && len_hit_r))
		else $error("start-up entered without length match and end frame");
	a_len_match: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(len_hit_r) |-> $past(cnt_r) == len_r)
		else $error("length reached flag set on wrong count");
	a_first_edge: assert property (@(posedge clk_i) disable iff (rst_i)
		s_su_entry ##0 (ctrl_r.done_dly == 3'h1) |-> ##2 !done_oe_o)
		else $error("completion pin not released after first edge");
	a_sync_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(in_start && synced && !done_seen_r && !ev_r.gsr_rel) |=> !ev_r.gsr_rel)
		else $error("set/reset released while completion line low");
	a_imm_event: assert property (@(posedge clk_i) disable iff (rst_i)
		(in_start && synced && $rose(done_seen_r) && idly == 3'h0) |=> io_active_o)
		else $error("immediate io activation missed");
	a_io_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(ev_r.io_act) && $past(in_start && synced)) |-> $past(di_cnt_r) >= $past(idly))
		else $error("io activated before its programmed edges");
	a_err_park: assert property (@(posedge clk_i) disable iff (rst_i)
		(top_st_r == cfgld_pkg::S_ERR) |=> !init_n_o)
		else $error("init not held low in error");
	a_csum_err: assert property (@(posedge clk_i) disable iff (rst_i)
		(bit_v && pst_r == cfgld_pkg::P_CSUM && cb_r == `CFGLD_BYTE_LAST && csum_bad)
		|=> pst_r == cfgld_pkg::P_ERR && err_r[2])
		else $error("bad checksum not flagged");
	a_auto_inc: assert property (@(posedge clk_i) disable iff (rst_i)
		(cfg_mem_we_o && !expl_r) |-> addr_r == cfg_mem_addr_o + 14'h0001)
		else $error("autoincrement address did not advance");
	a_done_held: assert property (@(posedge clk_i) disable iff (rst_i)
		(top_st_r == cfgld_pkg::S_CLR) |=> done_oe_o)
		else $error("completion pin not pulled low during clear");
endmodule
`default_nettype wire

/* src/cfgld_defs.svh */
// constants of the configuration frame loader: offsets, reset values, frame positions
`ifndef CFGLD_DEFS_SVH
`define CFGLD_DEFS_SVH
// ==========================================================
// register byte offsets
`define CFGLD_ADR_CTRL 8'h00
`define CFGLD_ADR_STAT 8'h04
`define CFGLD_ADR_LEN 8'h08
`define CFGLD_ADR_CNT 8'h0c
// ==========================================================
// reset values
`define CFGLD_CTRL_RST 12'h805
`define CFGLD_PART_ID_DEF 20'h0a5c3
// ==========================================================
// stream layout
`define CFGLD_PRE_WIN 5'h12
`define CFGLD_LEN_LAST 10'h017
`define CFGLD_ID_HDR 16'h5fff
`define CFGLD_ID_HDR_LAST 10'h00f
`define CFGLD_ID_MODE_LAST 10'h011
`define CFGLD_ID_OPT_LAST 10'h014
`define CFGLD_ID_LAST 10'h04f
`define CFGLD_ADDR_LAST 10'h00f
`define CFGLD_DATA_FIRST 10'h002
`define CFGLD_STOP_BITS 4'h8
`define CFGLD_BYTE_LAST 3'h7
`define CFGLD_POST_ADDR 14'h3fff
`define CFGLD_POST_CSUM 8'hff
`define CFGLD_MODE_AUTO 2'h0
`define CFGLD_MODE_EXPL 2'h1
// ==========================================================
// timing
`define CFGLD_DLY_MAX 3'h4
`define CFGLD_CNT_SAT 3'h7
`define CFGLD_INIT_CYC 2'h2
`endif

/* src/cfgld_pkg.sv */
// types shared by the configuration frame loader
package cfgld_pkg;
	// ==========================================================
	// top level phases
	typedef enum logic [2:0] {
		S_CLR = 3'b000, S_INIT = 3'b001, S_CFG = 3'b010,
		S_START = 3'b011, S_RUN = 3'b100, S_ERR = 3'b101
	} cfgld_top_st_t;
	// bit stream parser states
	typedef enum logic [2:0] {
		P_HUNT = 3'b000, P_LEN = 3'b001, P_STOP = 3'b010, P_FRM = 3'b011,
		P_CSUM = 3'b100, P_DONE = 3'b101, P_ERR = 3'b110
	} cfgld_parse_st_t;
	// start-up clocking modes
	typedef enum logic [1:0] {
		cfgclk_unsynced_startup = 2'b00, cfgclk_synced_startup = 2'b01,
		userclk_unsynced_startup = 2'b10, userclk_synced_startup = 2'b11
	} cfgld_su_mode_t;
	// software control word
	typedef struct packed {
		logic pullup_en;
		logic [2:0] io_dly;
		logic [2:0] gsr_dly;
		logic [2:0] done_dly;
		cfgld_su_mode_t mode;
	} cfgld_ctrl_t;
	// the three start-up events
	typedef struct packed {
		logic done_rel;
		logic gsr_rel;
		logic io_act;
	} cfgld_ev_t;
	// options carried by one load into the next
	typedef struct packed {
		logic no_clear;
		logic no_tri;
		logic no_gsr;
	} cfgld_opt_t;
endpackage

/* bench/cfgld_prom_model.sv */
// behavioural serial configuration source that plays one bit stream on the link
`timescale 1ns/10ps
`default_nettype none
module cfgld_prom_model (
	// link pins toward the loader
	output logic config_bit_clock_o,
	output logic cfg_data_o
);
	// high while a stream is being played
	logic busy;
	initial begin
		config_bit_clock_o = 1'b0;
		cfg_data_o = 1'b0;
		busy = 1'b0;
	end
	// ==========================================================
	// each bit is set up on the falling edge, fields go out msb first
	task automatic send(input logic q[$]);
		busy = 1'b1;
		foreach (q[i]) begin
			cfg_data_o = q[i];
			#40 config_bit_clock_o = 1'b1;
			#40 config_bit_clock_o = 1'b0;
		end
		// clock stands still; the released line must not keep its last level
		cfg_data_o = ~cfg_data_o;
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

/* bench/tb_cfgld_top.sv */
// self-checking bench of the configuration frame loader
`include "cfgld_defs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
$display("Error t=%0t got %h exp %h", $time, a, b); end end
`define WT(c) begin for (wt = 0; wt < 12000 && (c) !== 1'b1; wt++) @(posedge clk_i); \
if ((c) !== 1'b1) begin err_total++; report_and_stop(); end end
module tb_cfgld_top;
	// ==========================================================
	// drivers, monitors and bookkeeping
	logic clk_i, rst_i = 1, cyc = 0, stb = 0, we = 0, prog_n = 1, ext_low = 0, clr_seen = 0;
	logic uen = 0, dout; // user clock enable, completion pin drive level
	logic [1:0] msel = 2'h0; // mode pins
	logic [3:0] ucnt = 4'h0; // user clock divider, its msb is the user clock
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] dat = '0, rd, wdo;
	logic ack, lclk, ldat, doe, dpu, init_n, gsr, ioa, mclr, mwe;
	logic [13:0] maddr;
	logic [201:0] mdata;
	logic [13:0] wa[$];
	logic [201:0] wd[$];
	logic sq[$];
	logic [23:0] exp_len;
	int err_total = 0, samples_checked = 0, wt;
	// the completion wire: pulled up unless some party pulls it low
	wire logic done_w = ((doe && !dout) || ext_low) ? 1'b0 : 1'b1;
	// user clock of 80 ns, stands still until enabled so its absence can be seen
	always @(posedge clk_i) begin
		if (uen) ucnt <= ucnt + 4'h1;
	end
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	cfgld_prom_model prom (.config_bit_clock_o(lclk), .cfg_data_o(ldat));
	cfgld_top #(.DATA_BITS(202)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(wdo), .wb_ack_o(ack), .config_bit_clock_i(lclk), .cfg_data_i(ldat),
		.program_request_n_i(prog_n), .user_startup_clock_i(ucnt[3]), .mode_sel_i(msel),
		.done_i(done_w), .done_o(dout), .done_oe_o(doe), .done_pullup_en_o(dpu),
		.init_n_o(init_n), .gsr_hold_o(gsr), .io_active_o(ioa), .cfg_mem_clear_o(mclr),
		.cfg_mem_we_o(mwe), .cfg_mem_addr_o(maddr), .cfg_mem_data_o(mdata));
	// record every memory write and any clearing
	always @(posedge clk_i) begin
		if (mwe === 1'b1) begin
			wa.push_back(maddr);
			wd.push_back(mdata);
		end
		if (mclr === 1'b1) clr_seen <= 1'b1;
	end
	// ==========================================================
	// closing report, reached from the main sequence and every timeout
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// classic wishbone single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
		end
		if (ack !== 1'b1) begin err_total++; report_and_stop(); end
		rd = wdo;
		{cyc, stb, we} <= 3'b000;
	endtask
	// data pattern of one frame
	function automatic logic [201:0] pat(input logic [7:0] k);
		return {2'b11, {25{k}}};
	endfunction
	// one frame, left aligned in v, then its xor checksum and eight stop ones
	task automatic frm(input logic [207:0] v, input int n, input logic bad);
		logic [7:0] cs;
		cs = 8'h00;
		for (int i = 0; i < n; i++) begin
			sq.push_back(v[207-i]);
			cs[7 - i % 8] ^= v[207-i];
		end
		for (int i = 7; i >= 0; i--) sq.push_back(cs[i] ^ bad);
		repeat (8) sq.push_back(1'b1);
	endtask
	// build a whole load and start playing it; bad spoils the id checksum
	task automatic load(input logic [1:0] md, input logic [2:0] op, input logic bad);
		logic [39:0] hv;
		logic [23:0] pv;
		sq = {};
		wa = {};
		wd = {};
		frm({`CFGLD_ID_HDR, md, op, 39'h0, `CFGLD_PART_ID_DEF, 128'h0}, 80, bad);
		if (md == `CFGLD_MODE_AUTO) begin
			frm({2'b01, pat(8'h5a), 4'h0}, 208, 1'b0);
			frm({2'b01, pat(8'ha5), 4'h0}, 208, 1'b0);
		end else begin
			frm({2'b01, pat(8'h3c), 4'h0}, 208, 1'b0);
			frm({2'b00, 14'h0005, 192'h0}, 16, 1'b0);
			frm({2'b00, 14'h0009, 192'h0}, 16, 1'b0);
		end
		pv = {2'b00, `CFGLD_POST_ADDR, `CFGLD_POST_CSUM};
		for (int i = 23; i >= 0; i--) sq.push_back(pv[i]);
		exp_len = 24'(sq.size() + 40);
		hv = {8'hf2, exp_len, 8'hff};
		for (int i = 0; i < 40; i++) sq.push_front(hv[i]);
		// the tail of ones keeps link edges coming for the start-up steps
		repeat (24) sq.push_back(1'b1);
		fork
			prom.send(sq);
		join_none
		// let the player start, so that its busy flag is up before anyone waits on it
		@(posedge clk_i);
	endtask
	// program request pulse, then wait for the device to leave clear and raise init
	task automatic pulse;
		clr_seen = 1'b0;
		@(posedge clk_i);
		prog_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		prog_n <= 1'b1;
		`WT(init_n === 1'b1)
		repeat (10) @(posedge clk_i);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		wb(1'b0, `CFGLD_ADR_CTRL, 32'h0);
		`CHK(rd, {20'h0, `CFGLD_CTRL_RST})
		`CHK(dpu, 1'b1)
		wb(1'b0, 8'h40, 32'h0);
		`CHK(rd, 32'h0)
		// auto load with default start-up; keep memory on the next load
		load(`CFGLD_MODE_AUTO, 3'b100, 1'b0);
		`WT(doe === 1'b0)
		`CHK(ioa, 1'b0)
		`WT(ioa === 1'b1)
		`CHK(gsr, 1'b0)
		`WT(prom.busy === 1'b0)
		`CHK(wa.size(), 2)
		`CHK(wa[0], 14'h0000)
		`CHK(wd[0], pat(8'h5a))
		`CHK(wa[1], 14'h0001)
		`CHK(wd[1], pat(8'ha5))
		wb(1'b0, `CFGLD_ADR_STAT, 32'h0);
		`CHK({rd[12:11], rd[7], rd[2:0]}, 6'h34)
		wb(1'b0, `CFGLD_ADR_LEN, 32'h0);
		`CHK(rd[23:0], exp_len)
		// explicit reload on the user clock, gsr two user edges late, completion held low
		wb(1'b1, `CFGLD_ADR_CTRL, 32'h847);
		ext_low <= 1'b1;
		msel <= 2'h2;
		pulse();
		`CHK(clr_seen, 1'b0)
		`CHK(ioa, 1'b0)
		load(`CFGLD_MODE_EXPL, 3'b000, 1'b0);
		`WT(prom.busy === 1'b0)
		`CHK(doe, 1'b1)
		uen <= 1'b1;
		`WT(doe === 1'b0)
		repeat (40) @(posedge clk_i);
		`CHK({ioa, gsr}, 2'b01)
		ext_low <= 1'b0;
		`WT(ioa === 1'b1)
		`CHK(gsr, 1'b1)
		`WT(gsr === 1'b0)
		`CHK(wa.size(), 2)
		`CHK({wa[0], wa[1]}, {14'h0005, 14'h0009})
		`CHK(wd[1], pat(8'h3c))
		wb(1'b0, `CFGLD_ADR_STAT, 32'h0);
		`CHK({rd[14:13], rd[7]}, 3'h5)
		// spoiled checksum parks the device until a program request
		pulse();
		`CHK(clr_seen, 1'b1)
		load(`CFGLD_MODE_AUTO, 3'b000, 1'b1);
		`WT(init_n === 1'b0)
		wb(1'b0, `CFGLD_ADR_STAT, 32'h0);
		`CHK({rd[6], rd[2:0]}, 4'hd)
		`WT(prom.busy === 1'b0)
		`CHK({init_n, ioa}, 2'b00)
		pulse();
		`CHK(init_n, 1'b1)
		report_and_stop();
	end
endmodule
`default_nettype wire
